/* File: rtl/rss_pkg.sv */
// Purpose: Shared constants and types for the read sector sequencer
// Assumes: 10 MHz clock, APB register access
// Notes: Geometry is 411 cylinders, 19 tracks, 22 sectors
package rss_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int EOB_NS = 1500;
  localparam int EOB_CYC = (EOB_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_NS = 45000;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int EOB_W = $clog2(EOB_CYC + 1);
  localparam int BLK_W = $clog2(SETTLE_CYC + 1);

  // ----------------------------------------------------------------
  // Pack geometry
  // ----------------------------------------------------------------
  localparam logic [4:0] LAST_SEC = 5'h15;
  localparam logic [4:0] LAST_TRK = 5'h12;
  localparam logic [8:0] LAST_CYL = 9'h19A;
  localparam logic [1:0] IDX_LIMIT = 2'h3;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_DCYL = 8'h04;
  localparam logic [7:0] OFS_DST = 8'h08;
  localparam logic [7:0] OFS_CCYL = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_ERR1 = 8'h14;
  localparam logic [7:0] OFS_ALERT = 8'h18;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_CLR_BIT = 1;
  localparam int CMD_ECI_BIT = 2;
  localparam int DST_TRK_LSB = 8;
  localparam int DS_BUSY_BIT = 7;
  localparam int DS_LAST_BIT = 10;
  localparam int DS_COMP_BIT = 14;
  localparam int ER_AOE_BIT = 9;
  localparam int ER_IAE_BIT = 10;
  localparam int ER_DTE_BIT = 12;
  localparam int ER_OPI_BIT = 13;
  localparam int ER_DCK_BIT = 15;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] cyl;
    logic [4:0] trk;
    logic [4:0] sec;
  } rss_addr_t;

  localparam rss_addr_t ADDR_RESET = '0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEEK = 3'b001,
    ST_SEARCH = 3'b010,
    ST_DATA = 3'b011,
    ST_CORRECT = 3'b100,
    ST_EOB = 3'b101
  } rss_state_t;

endpackage

/* File: rtl/rss_sector_count.sv */
// Purpose: Sector counter locked to the servo sector and index pulses
// Assumes: Pulses are one clock wide and synchronous
// Notes: Runs free, also through seeks and correction
`timescale 1ns/1ps
`default_nettype none
module rss_sector_count
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Servo timing
  input wire logic sectorPulse,
  input wire logic indexPulse,
  // Rotational position
  output logic [4:0] sectorCount,
  output logic sectorHere
);

  // Never gated by the sequencer, so no resync after a seek
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sectorCount <= 5'h00;
      sectorHere <= 1'b0;
    end else begin
      sectorHere <= sectorPulse | indexPulse;
      if (indexPulse) begin
        sectorCount <= 5'h00;
      end else if (sectorPulse) begin
        sectorCount <= (sectorCount == LAST_SEC) ? 5'h00 : sectorCount + 5'h01;
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/rss_addr_step.sv */
// Purpose: Next sequential sector address for spiral transfers
// Assumes: Input address is valid or one past the pack end
// Notes: Cylinder steps past the last one to the illegal value
`timescale 1ns/1ps
`default_nettype none
module rss_addr_step
  import rss_pkg::*;
(
  // Present address
  input wire rss_addr_t curAddr,
  // Following address
  output rss_addr_t nextAddr,
  output logic packEnd
);

  always_comb begin
    nextAddr = curAddr;
    if (curAddr.sec != LAST_SEC) begin
      nextAddr.sec = curAddr.sec + 5'h01;
    end else begin
      nextAddr.sec = 5'h00;
      if (curAddr.trk != LAST_TRK) begin
        nextAddr.trk = curAddr.trk + 5'h01;
      end else begin
        nextAddr.trk = 5'h00;
        nextAddr.cyl = curAddr.cyl + 9'h001;
      end
    end
  end

  assign packEnd = (curAddr.cyl == LAST_CYL) && (curAddr.trk == LAST_TRK)
    && (curAddr.sec == LAST_SEC);

endmodule
`default_nettype wire

/* File: rtl/rss_read_seq.sv */
// Purpose: Read command sequencer with implied seeks and spiral reads
// Assumes: Drive strobes are one clock wide and synchronous
// Notes: APB slave with zero wait states
//
// Functional notes
// - With correction inhibited, a data error ends with data check and fault set.
// - Continue high after a data check goes on without lost revolution; flags hold.
// - Continue at block end starts search for next address; counter never stops.
// - Read compares desired and current cylinder and seeks first if they differ.
// - Search after a seek starts at the first sector pulse, no resync.
// - Matching header without error starts data and raises the sync strobe.
// - Continue after last sector of a track steps the track, sector zero.
// - Reading spirals while continue is high; stop leaves address one past.
// - Continue at last track and sector steps cylinder and seeks one cylinder.
// - Mid-transfer seek then waits for sector zero before the next strobe.
// - Block pulse rise always steps the desired address to the next sector.
// - Stop at last track and sector still steps cylinder but never seeks.
// - Continue at the last pack sector sets overflow, attention and last sector.
// - Last sector status sets at the ending block pulse rise, clears on command.
// - After the final pack sector the address reads cylinder 411, track 0, sector 0.
// - Sector pulses in the first 45 us of a command are ignored.
// - Correctable error with correction enabled stops transfer and runs correction.
// - Overflow error sets when the cylinder would pass 410; operation ends.
// - Timing failure sets its error and aborts the command at once.
// - Nonexistent cylinder, track or sector sets invalid address; nothing runs.
// - No completion in three index pulses sets incomplete; clear re-runs command.
// - Block pulse lasts 1.5 us; continue is sampled at its fall.
// - Any error sets composite and pending alert; only clears remove them.
`timescale 1ns/1ps
`default_nettype none
module rss_read_seq
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Servo and read channel
  input wire logic sectorPulse,
  input wire logic indexPulse,
  input wire logic headerError,
  input wire logic sectorDone,
  input wire logic eccError,
  input wire logic correctionDone,
  input wire logic timingFail,
  input wire logic seekDone,
  // Controller side
  input wire logic transferContinue,
  input wire logic busWideClearPulse,
  output logic syncClockStrobe,
  output logic endOfBlockPulse,
  output logic attentionLine,
  output logic faultDuringTransferLine,
  // Positioner and correction engine
  output logic seekStart,
  output logic [8:0] seekCylinder,
  output logic correctionStart
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rss_state_t state;
  rss_addr_t desiredAddr;
  rss_addr_t stepAddr;
  logic [8:0] currentCyl;
  logic [EOB_W-1:0] eobTimer;
  logic [BLK_W-1:0] blockTimer;
  logic [1:0] idxCount;
  logic [4:0] sectorCount;
  logic sectorHere;
  logic packEnd;
  logic packEndHeld;
  logic eccInhibit;
  logic dataCheckFlag;
  logic addrOverflowFlag;
  logic invalidAddrFlag;
  logic timingFaultFlag;
  logic incompleteOpFlag;
  logic lastSectorFlag;
  logic pendingAlertFlag;
  logic compositeFault;
  logic apbWrite;
  logic cmdWrite;
  logic goCmd;
  logic clearCmd;
  logic startCmd;
  logic addrOk;
  logic busy;
  logic sectorHit;
  logic goEob;
  logic eobFall;
  logic evDataCheck;
  logic evTiming;
  logic evIncomplete;
  logic evInvalid;
  logic evOverflow;
  logic abortNow;

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == OFS_CMD) || (a == OFS_DCYL) || (a == OFS_DST)
      || (a == OFS_CCYL) || (a == OFS_STAT) || (a == OFS_ERR1)
      || (a == OFS_ALERT);
  endfunction

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  rss_sector_count u_count (
    .clock(clock),
    .reset_n(reset_n),
    .sectorPulse(sectorPulse),
    .indexPulse(indexPulse),
    .sectorCount(sectorCount),
    .sectorHere(sectorHere)
  );

  rss_addr_step u_step (
    .curAddr(desiredAddr),
    .nextAddr(stepAddr),
    .packEnd(packEnd)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign apbWrite = psel && penable && pwrite && isMapped(paddr);
  assign cmdWrite = apbWrite && (paddr == OFS_CMD);
  assign goCmd = cmdWrite && pwdata[CMD_GO_BIT];
  assign clearCmd = (cmdWrite && pwdata[CMD_CLR_BIT]) || busWideClearPulse;
  assign busy = (state != ST_IDLE);
  // Re-run after a clear only when the last attempt timed out
  assign startCmd = !busy && (goCmd || (clearCmd && incompleteOpFlag));
  assign addrOk = (desiredAddr.cyl <= LAST_CYL) && (desiredAddr.trk <= LAST_TRK)
    && (desiredAddr.sec <= LAST_SEC);
  assign sectorHit = sectorHere && (blockTimer == '0)
    && (sectorCount == desiredAddr.sec);
  assign goEob = ((state == ST_DATA) && sectorDone && !(eccError && !eccInhibit))
    || ((state == ST_CORRECT) && correctionDone);
  assign eobFall = (state == ST_EOB) && (eobTimer == EOB_W'(1));
  assign evDataCheck = (state == ST_DATA) && sectorDone && eccError;
  assign evTiming = busy && timingFail;
  assign evIncomplete = busy && indexPulse && (idxCount == IDX_LIMIT - 2'h1);
  assign evInvalid = startCmd && !addrOk;
  assign evOverflow = eobFall && packEndHeld && transferContinue;
  assign abortNow = evTiming || evIncomplete;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      currentCyl <= 9'h000;
      eobTimer <= '0;
      blockTimer <= '0;
      idxCount <= 2'h0;
      packEndHeld <= 1'b0;
      seekStart <= 1'b0;
      seekCylinder <= 9'h000;
      syncClockStrobe <= 1'b0;
      correctionStart <= 1'b0;
      endOfBlockPulse <= 1'b0;
    end else begin
      seekStart <= 1'b0;
      syncClockStrobe <= 1'b0;
      correctionStart <= 1'b0;
      if (blockTimer != '0) begin
        blockTimer <= blockTimer - BLK_W'(1);
      end
      if (busy && indexPulse) begin
        idxCount <= idxCount + 2'h1;
      end
      if (abortNow) begin
        state <= ST_IDLE;
        endOfBlockPulse <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            if (startCmd && addrOk) begin
              blockTimer <= BLK_W'(SETTLE_CYC);
              idxCount <= 2'h0;
              if (desiredAddr.cyl != currentCyl) begin
                state <= ST_SEEK;
                seekStart <= 1'b1;
                seekCylinder <= desiredAddr.cyl;
              end else begin
                state <= ST_SEARCH;
              end
            end
          end
          ST_SEEK: begin
            if (seekDone) begin
              currentCyl <= seekCylinder;
              state <= ST_SEARCH;
            end
          end
          ST_SEARCH: begin
            // After a cylinder step this waits for sector zero
            if (sectorHit) begin
              if (headerError) begin
                state <= ST_IDLE;
              end else begin
                state <= ST_DATA;
                syncClockStrobe <= 1'b1;
                idxCount <= 2'h0;
              end
            end
          end
          ST_DATA: begin
            if (evDataCheck && !eccInhibit) begin
              state <= ST_CORRECT;
              correctionStart <= 1'b1;
            end
          end
          ST_CORRECT: begin
          end
          ST_EOB: begin
            eobTimer <= eobTimer - EOB_W'(1);
            if (eobFall) begin
              endOfBlockPulse <= 1'b0;
              // Relies on continue being stable here
              if (packEndHeld || !transferContinue) begin
                state <= ST_IDLE;
              end else if (desiredAddr.cyl != currentCyl) begin
                state <= ST_SEEK;
                seekStart <= 1'b1;
                seekCylinder <= desiredAddr.cyl;
              end else begin
                state <= ST_SEARCH;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
        if (goEob) begin
          state <= ST_EOB;
          endOfBlockPulse <= 1'b1;
          eobTimer <= EOB_W'(EOB_CYC);
          packEndHeld <= packEnd;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Desired address and settings
  // ----------------------------------------------------------------
  // Address writes are dropped while a command runs; the inhibit bit still updates
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      desiredAddr <= ADDR_RESET;
      eccInhibit <= 1'b0;
    end else begin
      if (cmdWrite) begin
        eccInhibit <= pwdata[CMD_ECI_BIT];
      end
      if (goEob && !abortNow) begin
        desiredAddr <= stepAddr;
      end else if (apbWrite && !busy && (paddr == OFS_DCYL)) begin
        desiredAddr.cyl <= pwdata[8:0];
      end else if (apbWrite && !busy && (paddr == OFS_DST)) begin
        desiredAddr.trk <= pwdata[DST_TRK_LSB +: 5];
        desiredAddr.sec <= pwdata[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Error and status flags
  // ----------------------------------------------------------------
  // Clears come first so a same-cycle event wins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dataCheckFlag <= 1'b0;
      faultDuringTransferLine <= 1'b0;
      addrOverflowFlag <= 1'b0;
      invalidAddrFlag <= 1'b0;
      timingFaultFlag <= 1'b0;
      incompleteOpFlag <= 1'b0;
      attentionLine <= 1'b0;
      pendingAlertFlag <= 1'b0;
    end else begin
      if (clearCmd) begin
        dataCheckFlag <= 1'b0;
        faultDuringTransferLine <= 1'b0;
        addrOverflowFlag <= 1'b0;
        invalidAddrFlag <= 1'b0;
        timingFaultFlag <= 1'b0;
        incompleteOpFlag <= 1'b0;
        attentionLine <= 1'b0;
        pendingAlertFlag <= 1'b0;
      end
      if (evDataCheck && !abortNow) begin
        dataCheckFlag <= 1'b1;
        faultDuringTransferLine <= 1'b1;
      end
      if (evOverflow && !abortNow) begin
        addrOverflowFlag <= 1'b1;
        attentionLine <= 1'b1;
      end
      if (evInvalid) begin
        invalidAddrFlag <= 1'b1;
        attentionLine <= 1'b1;
      end
      if (evTiming) begin
        timingFaultFlag <= 1'b1;
        attentionLine <= 1'b1;
      end
      if (evIncomplete && !evTiming) begin
        incompleteOpFlag <= 1'b1;
        attentionLine <= 1'b1;
      end
      if ((evDataCheck || evOverflow) && !abortNow || evInvalid || abortNow) begin
        pendingAlertFlag <= 1'b1;
      end
    end
  end

  assign compositeFault = dataCheckFlag || addrOverflowFlag || invalidAddrFlag
    || timingFaultFlag || incompleteOpFlag;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lastSectorFlag <= 1'b0;
    end else begin
      if (goCmd) begin
        lastSectorFlag <= 1'b0;
      end
      if (goEob && !abortNow && (packEnd || !transferContinue)) begin
        lastSectorFlag <= 1'b1;
      end
      if (eobFall && !abortNow && (packEndHeld || !transferContinue)) begin
        lastSectorFlag <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB read side
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable && !isMapped(paddr);

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      OFS_CMD: prdata[CMD_ECI_BIT] = eccInhibit;
      OFS_DCYL: prdata[8:0] = desiredAddr.cyl;
      OFS_DST: begin
        prdata[DST_TRK_LSB +: 5] = desiredAddr.trk;
        prdata[4:0] = desiredAddr.sec;
      end
      OFS_CCYL: prdata[8:0] = currentCyl;
      OFS_STAT: begin
        prdata[DS_COMP_BIT] = compositeFault;
        prdata[DS_LAST_BIT] = lastSectorFlag;
        prdata[DS_BUSY_BIT] = busy;
      end
      OFS_ERR1: begin
        prdata[ER_DCK_BIT] = dataCheckFlag;
        prdata[ER_OPI_BIT] = incompleteOpFlag;
        prdata[ER_DTE_BIT] = timingFaultFlag;
        prdata[ER_IAE_BIT] = invalidAddrFlag;
        prdata[ER_AOE_BIT] = addrOverflowFlag;
      end
      OFS_ALERT: prdata[0] = pendingAlertFlag;
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  localparam int EOB_LEN = EOB_CYC;

  sequence s_eob_fall;
    (state == ST_EOB) && (eobTimer == EOB_W'(1)) && !abortNow;
  endsequence

  sequence s_bad_data;
    (state == ST_DATA) && sectorDone && eccError && !abortNow;
  endsequence

  a_eob_width: assert property ($rose(endOfBlockPulse) |-> ##EOB_LEN !endOfBlockPulse)
    else $error("end of block pulse has wrong length");
  a_eob_hold: assert property ($rose(endOfBlockPulse) |-> endOfBlockPulse[*8])
    else $error("end of block pulse fell early");
  a_inhibit_end: assert property (s_bad_data ##0 eccInhibit
    |=> dataCheckFlag && faultDuringTransferLine && !correctionStart)
    else $error("inhibited data error handled wrongly");
  a_correct_run: assert property (s_bad_data ##0 !eccInhibit
    |=> correctionStart && (state == ST_CORRECT))
    else $error("correction not started");
  a_addr_step: assert property ($rose(endOfBlockPulse) && ($past(desiredAddr.sec) != LAST_SEC)
    |-> desiredAddr.sec == $past(desiredAddr.sec) + 5'h01)
    else $error("sector field did not advance");
  a_overflow_end: assert property (s_eob_fall ##0 (packEndHeld && transferContinue)
    |=> addrOverflowFlag && attentionLine && lastSectorFlag && !busy)
    else $error("overflow not reported");
  a_mid_seek: assert property (s_eob_fall ##0 (!packEndHeld && transferContinue
    && desiredAddr.cyl != currentCyl) |=> seekStart && (state == ST_SEEK))
    else $error("mid transfer seek missing");
  a_stop_noseek: assert property (s_eob_fall ##0 !transferContinue
    |=> !busy && !seekStart)
    else $error("stopped transfer still seeks");
  a_timing_abort: assert property (evTiming |=> !busy && timingFaultFlag)
    else $error("timing fault did not abort");
  a_seek_first: assert property (startCmd && addrOk && (desiredAddr.cyl != currentCyl)
    |=> seekStart ##1 !syncClockStrobe)
    else $error("implied seek missing");
  a_block_window: assert property (syncClockStrobe |-> blockTimer == '0)
    else $error("sector found inside settle window");
  a_last_clear: assert property (goCmd && !busy |=> !lastSectorFlag)
    else $error("last sector flag not cleared");

endmodule
`default_nettype wire

/* File: verification/rss_ctrl_model.sv */
// Purpose: Servo, positioner and controller stand-in for the sequencer
// Assumes: Sector period of 40 clocks, 22 sectors a turn
// Notes: Short sectors keep a full turn under 900 clocks
`timescale 1ns/1ps
`default_nettype none
module rss_ctrl_model
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // From bench and sequencer
  input wire logic contReq,
  input wire logic endOfBlockPulse,
  input wire logic syncClockStrobe,
  input wire logic seekStart,
  // To the sequencer
  output logic sectorPulse,
  output logic indexPulse,
  output logic sectorDone,
  output logic seekDone,
  output logic transferContinue
);
  logic [5:0] tick;
  logic [4:0] sec;
  logic [4:0] sd;
  logic [4:0] sk;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick <= 6'h00;
      sec <= 5'h00;
    end else begin
      tick <= (tick == 6'h27) ? 6'h00 : tick + 6'h01;
      if (tick == 6'h27) sec <= (sec == LAST_SEC) ? 5'h00 : sec + 5'h01;
    end
  end
  assign sectorPulse = (tick == 6'h27);
  assign indexPulse = sectorPulse && (sec == LAST_SEC);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sd <= 5'h00;
      sk <= 5'h00;
    end else begin
      sd <= syncClockStrobe ? 5'h0A : sd - {4'h0, sd != 5'h00};
      sk <= seekStart ? 5'h14 : sk - {4'h0, sk != 5'h00};
    end
  end
  assign sectorDone = (sd == 5'h01);
  assign seekDone = (sk == 5'h01);

  // Level may only move while the block pulse is low
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) transferContinue <= 1'b0;
    else if (!endOfBlockPulse) transferContinue <= contReq;
  end
endmodule
`default_nettype wire

/* File: verification/disk_read_sector_sequencer_tb_top.sv */
// Purpose: Self-checking bench for the read sector sequencer
// Assumes: Zero wait APB slave, model supplies servo timing
// Notes: Bench stands in for the correction engine
`timescale 1ns/1ps
`default_nettype none
module disk_read_sector_sequencer_tb_top import rss_pkg::*;;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic timingFail = 1'b0, busWideClearPulse = 1'b0, contReq = 1'b0, eccError = 1'b0;
  logic [31:0] prdata, rdS;
  logic pready, pslverr, slvS, sectorPulse, indexPulse, sectorDone, seekDone;
  logic transferContinue, syncClockStrobe, endOfBlockPulse, attentionLine, seekStart;
  logic correctionStart, faultDuringTransferLine, ecc_correction_inhibit = 1'b0, correctionDone = 1'b0;
  logic [8:0] seekCylinder;
  int miscompares = 0, nTests = 0, seekCnt = 0, corrCnt = 0;

  rss_read_seq rss_read_seq_i (.clock, .reset_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .sectorPulse, .indexPulse,
    .headerError(1'b0), .sectorDone, .eccError, .correctionDone,
    .timingFail, .seekDone, .transferContinue, .busWideClearPulse, .syncClockStrobe,
    .endOfBlockPulse, .attentionLine, .faultDuringTransferLine, .seekStart,
    .seekCylinder, .correctionStart);
  rss_ctrl_model rss_ctrl_model_i (.clock, .reset_n, .contReq, .endOfBlockPulse,
    .syncClockStrobe, .seekStart, .sectorPulse, .indexPulse, .sectorDone, .seekDone,
    .transferContinue);

  always #50 clock = ~clock;
  // Event counters, and a correction engine that answers at once
  always @(posedge clock) begin
    correctionDone <= correctionStart;
    if (seekStart === 1'b1) seekCnt <= seekCnt + 1;
    if (correctionStart === 1'b1) corrCnt <= corrCnt + 1;
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdS = prdata;
    slvS = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    nTests++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e, rdS & m);
  endtask

  task automatic start(input logic [8:0] c, input logic [4:0] t, input logic [4:0] s);
    apb(1'b1, OFS_DCYL, {23'h0, c});
    apb(1'b1, OFS_DST, {19'h0, t, 3'h0, s});
    apb(1'b1, OFS_CMD, {29'h0, ecc_correction_inhibit, 2'b01});
  endtask

  task automatic waitEob();
    int i;
    for (i = 0; i < 3000 && endOfBlockPulse !== 1'b1; i++) @(negedge clock);
    for (i = 0; i < 40 && endOfBlockPulse !== 1'b0; i++) @(negedge clock);
    chk("eob width", EOB_CYC, i);
    repeat (3) @(posedge clock);
  endtask

  task automatic t_inv();
    rdChk("unmapped", 8'h1C, 32'hFFFF_FFFF, 32'h0);
    chk("slverr", 32'h1, {31'h0, slvS});
    start(9'h19B, 5'h00, 5'h00);
    rdChk("invalid", OFS_ERR1, 32'hFFFF_FFFF, 32'h0000_0400);
    rdChk("composite", OFS_STAT, 32'h0000_4080, 32'h0000_4000);
    rdChk("alert", OFS_ALERT, 32'h0000_0001, 32'h0000_0001);
    chk("attention", 32'h1, {31'h0, attentionLine});
    apb(1'b1, OFS_CMD, 32'h0000_0002);
    rdChk("cleared", OFS_ERR1, 32'hFFFF_FFFF, 32'h0);
    $display("done invalid");
  endtask

  task automatic t_one();
    int i;
    start(9'h005, 5'h02, LAST_SEC);
    for (i = 0; i < 20 && seekStart !== 1'b1; i++) @(negedge clock);
    chk("seek target", 32'h5, {23'h0, seekCylinder});
    waitEob();
    rdChk("next addr", OFS_DST, 32'hFFFF_FFFF, 32'h0000_0300);
    rdChk("last sector", OFS_STAT, 32'h0000_0480, 32'h0000_0400);
    rdChk("cur cyl", OFS_CCYL, 32'hFFFF_FFFF, 32'h5);
    $display("done one");
  endtask

  task automatic t_spiral();
    int i;
    contReq <= 1'b1;
    start(9'h005, LAST_TRK, LAST_SEC);
    for (i = 0; i < 3000 && seekStart !== 1'b1; i++) @(negedge clock);
    chk("mid seek", 32'h6, {23'h0, seekCylinder});
    @(posedge clock);
    contReq <= 1'b0;
    waitEob();
    rdChk("spiral cyl", OFS_DCYL, 32'hFFFF_FFFF, 32'h6);
    rdChk("spiral dst", OFS_DST, 32'hFFFF_FFFF, 32'h1);
    $display("done spiral");
  endtask

  task automatic t_end(input logic [8:0] c);
    int n;
    start(c, LAST_TRK, LAST_SEC);
    repeat (2) @(posedge clock);
    n = seekCnt;
    waitEob();
    repeat (30) @(posedge clock);
    chk("no seek", n, seekCnt);
    rdChk("end cyl", OFS_DCYL, 32'hFFFF_FFFF, {23'h0, c + 9'h001});
    rdChk("end dst", OFS_DST, 32'hFFFF_FFFF, 32'h0);
    $display("done end");
  endtask

  task automatic t_ovf();
    contReq <= 1'b1;
    start(LAST_CYL, LAST_TRK, LAST_SEC);
    waitEob();
    rdChk("overflow", OFS_ERR1, 32'hFFFF_FFFF, 32'h0000_0200);
    rdChk("ovf status", OFS_STAT, 32'h0000_4480, 32'h0000_4400);
    chk("ovf attention", 32'h1, {31'h0, attentionLine});
    busWideClearPulse <= 1'b1;
    contReq <= 1'b0;
    @(posedge clock);
    busWideClearPulse <= 1'b0;
    rdChk("init clear", OFS_ERR1, 32'hFFFF_FFFF, 32'h0);
    $display("done overflow");
  endtask

  task automatic t_ecc(input logic inh);
    ecc_correction_inhibit = inh;
    eccError <= 1'b1;
    start(LAST_CYL, 5'h00, 5'h00);
    waitEob();
    eccError <= 1'b0;
    ecc_correction_inhibit = 1'b0;
    chk("corrections", {31'h0, !inh}, corrCnt);
    rdChk("data check", OFS_ERR1, 32'hFFFF_FFFF, 32'h0000_8000);
    chk("fault line", 32'h1, {31'h0, faultDuringTransferLine});
    apb(1'b1, OFS_CMD, 32'h0000_0002);
    @(posedge clock);
    chk("fault clear", 32'h0, {31'h0, faultDuringTransferLine});
    $display("done ecc");
  endtask

  task automatic t_dte();
    start(LAST_CYL, 5'h00, 5'h00);
    timingFail <= 1'b1;
    @(posedge clock);
    timingFail <= 1'b0;
    rdChk("timing", OFS_ERR1, 32'hFFFF_FFFF, 32'h0000_1000);
    rdChk("aborted", OFS_STAT, 32'h0000_0080, 32'h0);
    $display("done timing");
  endtask

  task automatic endOfTest();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    t_inv();
    t_one();
    t_spiral();
    t_end(9'h007);
    t_end(LAST_CYL);
    t_ovf();
    t_ecc(1'b1);
    t_ecc(1'b0);
    t_dte();
    endOfTest();
  end

  // Nine commands of at most three turns each fit well inside this
  initial begin
    repeat (40000) @(posedge clock);
    miscompares++;
    endOfTest();
  end
endmodule
`default_nettype wire
